// ---- src/tlbt_top.sv ----
// translation buffer with test access through a command and a data test register
// assumes register moves, translations and fills come from logic on mclk
// What this block does
// - four ways, eight sets, 32 entries
// - data entry: page address plus two attributes
// - tag entry: 17-bit tag, four protection bits
// - per-set three-bit pseudo-LRU, cache algorithm
// - command layout: address, protection, operation bit
// - low address bits pick set, rest tag
// - command write starts write or lookup
// - write pairs store true bit
// - lookup pairs force miss, match, or wildcard
// - data register field layout
// - data bit 4 picks LRU or given way
// - entry write ignores data LRU field
// - every entry write makes it most recent
// - lookup result in data bit 4
// - hit loads way, entry, old LRU
// - miss leaves other data bits unchanged
// - lookup hit makes entry most recent
// - duplicate address in a set never hits
// - tests work while translation is active
`timescale 1ns/10ps
`default_nettype none
`include "tlbt_map.svh"
module tlbt_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic tr_wr_en,
    input wire logic tr_wr_sel,
    input wire logic [31:0] tr_wr_data,
    input wire logic tr_rd_en,
    input wire logic tr_rd_sel,
    output logic [31:0] tr_rd_data,
    output logic tr_rd_valid,
    input wire logic xl_valid,
    input wire logic [19:0] xl_lin,
    output logic xl_done,
    output logic xl_hit,
    output logic [19:0] xl_phys,
    output logic xl_cache_inhibit,
    output logic xl_store_through,
    input wire logic fill_valid,
    input wire logic [19:0] fill_lin,
    input wire logic [19:0] fill_phys,
    input wire logic fill_cache_inhibit,
    input wire logic fill_store_through,
    input wire logic fill_user,
    input wire logic fill_rw,
    input wire logic fill_dirty,
    output logic fill_done
);
    localparam int WAYS = 4;
    localparam int SETS = 8;

    tlbt_pkg::tlbt_tag_t tag_mem [0:SETS-1][0:WAYS-1];
    tlbt_pkg::tlbt_tag_t next_tag [0:SETS-1][0:WAYS-1];
    tlbt_pkg::tlbt_data_t data_mem [0:SETS-1][0:WAYS-1];
    tlbt_pkg::tlbt_data_t next_data [0:SETS-1][0:WAYS-1];
    tlbt_pkg::tlbt_lru_t lru_mem [0:SETS-1];
    tlbt_pkg::tlbt_lru_t next_lru [0:SETS-1];
    logic [31:0] cmd_reg, next_cmd;
    logic [19:0] dr_phys, next_dr_phys;
    logic dr_ci, next_dr_ci, dr_st, next_dr_st, dr_flag, next_dr_flag;
    tlbt_pkg::tlbt_lru_t dr_lru, next_dr_lru;
    tlbt_pkg::tlbt_way_t dr_ptr, next_dr_ptr;
    logic [31:0] next_rd_data;
    logic next_rd_valid, next_xl_done, next_xl_hit, next_xl_ci, next_xl_st, next_fill_done;
    logic [19:0] next_xl_phys;
    logic wr_cmd, wr_dat, test_wr, test_lk, fill_taken;
    tlbt_pkg::tlbt_set_t t_set, x_set, f_set, u_set;
    logic [16:0] t_tag;
    logic [2:0] t_cnt, x_cnt;
    logic t_hit, x_hit, do_upd;
    tlbt_pkg::tlbt_way_t t_way, x_way, u_way, victim;
    tlbt_pkg::tlbt_lru_t lru_upd;

    // one pair of command bits against a stored protection bit
    function automatic logic pair_match(input logic b, input logic bn, input logic s);
        pair_match = (b & bn) | (b & ~bn & s) | (~b & bn & ~s);
    endfunction

    // command fields decoded from the write word
    // set index and tag from the linear address
    assign wr_cmd = tr_wr_en && (tr_wr_sel == `TLBT_SEL_CMD);
    assign wr_dat = tr_wr_en && (tr_wr_sel == `TLBT_SEL_DATA);
    assign t_set = tr_wr_data[`TLBT_CMD_SET_HI:`TLBT_CMD_LIN_LO];
    assign t_tag = tr_wr_data[`TLBT_CMD_LIN_HI:`TLBT_CMD_TAG_LO];
    // the command write itself starts the operation
    assign test_wr = wr_cmd && !tr_wr_data[`TLBT_CMD_OP_BIT];
    assign test_lk = wr_cmd && tr_wr_data[`TLBT_CMD_OP_BIT];
    assign x_set = xl_lin[2:0];
    assign f_set = fill_lin[2:0];
    // test commands win the single update port; a fill waits a cycle
    assign fill_taken = fill_valid && !wr_cmd;
    assign u_set = wr_cmd ? t_set : (fill_taken ? f_set : x_set);

    // match both lookups; only a single matching way counts as a hit
    always_comb begin
        t_cnt = 3'h0;
        x_cnt = 3'h0;
        t_way = 2'h0;
        x_way = 2'h0;
        for (int w = 0; w < WAYS; w++) begin
            // forced miss, exact match or wildcard per pair
            if (tag_mem[t_set][w].tag == t_tag
                && tag_mem[t_set][w].valid == tr_wr_data[`TLBT_CMD_V_BIT]
                && pair_match(tr_wr_data[`TLBT_CMD_D_BIT], tr_wr_data[`TLBT_CMD_DN_BIT],
                              tag_mem[t_set][w].dirty)
                && pair_match(tr_wr_data[`TLBT_CMD_U_BIT], tr_wr_data[`TLBT_CMD_UN_BIT],
                              tag_mem[t_set][w].user)
                && pair_match(tr_wr_data[`TLBT_CMD_W_BIT], tr_wr_data[`TLBT_CMD_WN_BIT],
                              tag_mem[t_set][w].rw)) begin
                t_cnt = t_cnt + 3'h1;
                t_way = 2'(w);
            end
            if (tag_mem[x_set][w].valid && tag_mem[x_set][w].tag == xl_lin[19:3]) begin
                x_cnt = x_cnt + 3'h1;
                x_way = 2'(w);
            end
        end
        // duplicates in one set give no hit
        t_hit = (t_cnt == 3'h1);
        x_hit = (x_cnt == 3'h1);
    end

    // pick the way whose LRU state is touched this cycle
    always_comb begin
        u_way = x_way;
        do_upd = 1'b0;
        if (test_wr) begin
            // way from data bit 4: given pointer or pseudo-LRU
            // the pointer was loaded by an earlier data write or lookup hit
            u_way = dr_flag ? dr_ptr : victim;
            do_upd = 1'b1;
        end else if (test_lk) begin
            u_way = t_way;
            do_upd = t_hit;
        end else if (fill_taken) begin
            u_way = victim;
            do_upd = 1'b1;
        end else begin
            // normal translations run beside test access
            do_upd = xl_valid && x_hit;
        end
    end

    tlbt_plru u_plru (
        .lru_in(lru_mem[u_set]),
        .used_way(u_way),
        .lru_out(lru_upd),
        .victim(victim)
    );

    // next state of arrays, test registers and answer outputs
    always_comb begin
        next_tag = tag_mem;
        next_data = data_mem;
        next_lru = lru_mem;
        next_cmd = cmd_reg;
        next_dr_phys = dr_phys;
        next_dr_ci = dr_ci;
        next_dr_st = dr_st;
        next_dr_lru = dr_lru;
        next_dr_flag = dr_flag;
        next_dr_ptr = dr_ptr;
        // data register fields as software writes them
        if (wr_dat) begin
            next_dr_phys = tr_wr_data[`TLBT_DAT_PHYS_HI:`TLBT_DAT_PHYS_LO];
            next_dr_ci = tr_wr_data[`TLBT_DAT_CI_BIT];
            next_dr_st = tr_wr_data[`TLBT_DAT_ST_BIT];
            next_dr_lru = tr_wr_data[`TLBT_DAT_LRU_HI:`TLBT_DAT_LRU_LO];
            next_dr_flag = tr_wr_data[`TLBT_DAT_FLAG_BIT];
            next_dr_ptr = tr_wr_data[`TLBT_DAT_PTR_HI:`TLBT_DAT_PTR_LO];
        end
        if (wr_cmd) begin
            next_cmd = tr_wr_data & `TLBT_CMD_MASK;
        end
        if (test_wr) begin
            // the true bit of each pair is stored
            // tag and protection bits of the entry
            next_tag[t_set][u_way] = {t_tag, tr_wr_data[`TLBT_CMD_V_BIT],
                                      tr_wr_data[`TLBT_CMD_U_BIT], tr_wr_data[`TLBT_CMD_W_BIT],
                                      tr_wr_data[`TLBT_CMD_D_BIT]};
            // the data LRU field plays no part here
            next_data[t_set][u_way] = {dr_phys, dr_ci, dr_st};
        end else if (fill_taken) begin
            next_tag[f_set][u_way] = {fill_lin[19:3], 1'b1, fill_user, fill_rw, fill_dirty};
            next_data[f_set][u_way] = {fill_phys, fill_cache_inhibit, fill_store_through};
        end
        if (do_upd) begin
            next_lru[u_set] = lru_upd;
        end
        if (test_lk) begin
            next_dr_flag = t_hit;
            // way, entry and the pre-update LRU state
            // a miss leaves the other fields as they were
            if (t_hit) begin
                next_dr_phys = data_mem[t_set][t_way].phys;
                next_dr_ci = data_mem[t_set][t_way].page_cache_inhibit;
                next_dr_st = data_mem[t_set][t_way].page_store_through;
                next_dr_lru = lru_mem[t_set];
                next_dr_ptr = t_way;
            end
        end
        next_xl_done = xl_valid;
        next_xl_hit = xl_valid && x_hit;
        next_xl_phys = data_mem[x_set][x_way].phys;
        next_xl_ci = data_mem[x_set][x_way].page_cache_inhibit;
        next_xl_st = data_mem[x_set][x_way].page_store_through;
        next_fill_done = fill_taken;
        next_rd_valid = tr_rd_en;
        // a read sees the result of a same-cycle command
        next_rd_data = tr_rd_data;
        if (tr_rd_en) begin
            next_rd_data = (tr_rd_sel == `TLBT_SEL_CMD) ? next_cmd :
                {next_dr_phys, next_dr_ci, next_dr_st, next_dr_lru, 2'b00, next_dr_flag,
                 next_dr_ptr, 2'b00};
        end
    end

    // register everything; arrays clear so no entry is valid after reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            for (int s = 0; s < SETS; s++) begin
                lru_mem[s] <= `TLBT_RST_LRU;
                for (int w = 0; w < WAYS; w++) begin
                    tag_mem[s][w] <= '0;
                    data_mem[s][w] <= '0;
                end
            end
            cmd_reg <= `TLBT_RST_WORD;
            dr_phys <= 20'h00000;
            dr_ci <= 1'b0;
            dr_st <= 1'b0;
            dr_lru <= `TLBT_RST_LRU;
            dr_flag <= 1'b0;
            dr_ptr <= 2'h0;
            tr_rd_data <= `TLBT_RST_WORD;
            tr_rd_valid <= 1'b0;
            xl_done <= 1'b0;
            xl_hit <= 1'b0;
            xl_phys <= 20'h00000;
            xl_cache_inhibit <= 1'b0;
            xl_store_through <= 1'b0;
            fill_done <= 1'b0;
        end else begin
            tag_mem <= next_tag;
            data_mem <= next_data;
            lru_mem <= next_lru;
            cmd_reg <= next_cmd;
            dr_phys <= next_dr_phys;
            dr_ci <= next_dr_ci;
            dr_st <= next_dr_st;
            dr_lru <= next_dr_lru;
            dr_flag <= next_dr_flag;
            dr_ptr <= next_dr_ptr;
            tr_rd_data <= next_rd_data;
            tr_rd_valid <= next_rd_valid;
            xl_done <= next_xl_done;
            xl_hit <= next_xl_hit;
            xl_phys <= next_xl_phys;
            xl_cache_inhibit <= next_xl_ci;
            xl_store_through <= next_xl_st;
            fill_done <= next_fill_done;
        end
    end

    // checks on the test operations
    a_lookup_flag: assert property (@(posedge mclk) disable iff (!resetn)
        test_lk |=> dr_flag == $past(t_hit)) else $error("lookup flag wrong");
    a_hit_entry: assert property (@(posedge mclk) disable iff (!resetn)
        test_lk && t_hit |=> dr_ptr == $past(t_way)
        && {dr_phys, dr_ci, dr_st} == data_mem[$past(t_set)][dr_ptr])
        else $error("hit entry not reported");
    a_hit_old_lru: assert property (@(posedge mclk) disable iff (!resetn)
        test_lk && t_hit |=> dr_lru == $past(lru_mem[t_set]))
        else $error("reported lru is not the old state");
    a_hit_mru: assert property (@(posedge mclk) disable iff (!resetn)
        test_lk && t_hit |=> lru_mem[$past(t_set)][0] == ~dr_ptr[1]
        && lru_mem[$past(t_set)][dr_ptr[1] ? 2 : 1] == ~dr_ptr[0])
        else $error("hit entry not most recent");
    a_write_mru: assert property (@(posedge mclk) disable iff (!resetn)
        test_wr |=> lru_mem[$past(t_set)][0] == ~$past(u_way[1])
        && lru_mem[$past(t_set)][$past(u_way[1]) ? 2 : 1] == ~$past(u_way[0]))
        else $error("written entry not most recent");
    a_write_tag: assert property (@(posedge mclk) disable iff (!resetn)
        test_wr |=> tag_mem[$past(t_set)][$past(u_way)].tag == $past(t_tag)
        && tag_mem[$past(t_set)][$past(u_way)].valid == $past(tr_wr_data[11]))
        else $error("tag not stored");
    a_write_ptr: assert property (@(posedge mclk) disable iff (!resetn)
        test_wr && dr_flag |-> u_way == dr_ptr) else $error("given way not used");
    a_write_dirty: assert property (@(posedge mclk) disable iff (!resetn)
        test_wr && tr_wr_data[10:9] == 2'b01 |=> !tag_mem[$past(t_set)][$past(u_way)].dirty)
        else $error("pair 0,1 did not store 0");
    a_forced_miss: assert property (@(posedge mclk) disable iff (!resetn)
        test_lk && tr_wr_data[8:7] == 2'b00 |=> !dr_flag) else $error("forced miss hit");
    a_lru_ignored: assert property (@(posedge mclk) disable iff (!resetn)
        test_wr |=> $stable(dr_lru)) else $error("write changed data lru field");
    a_dup_nohit: assert property (@(posedge mclk) disable iff (!resetn)
        test_lk && t_cnt > 3'h1 |=> !dr_flag) else $error("duplicate address hit");
    a_read_fresh: assert property (@(posedge mclk) disable iff (!resetn)
        tr_rd_en && tr_rd_sel |=> tr_rd_valid && tr_rd_data[4] == dr_flag)
        else $error("data read stale");
endmodule // tlbt_top
`default_nettype wire

// ---- src/tlbt_map.svh ----
// bit positions, selector codes and reset values of the translation buffer test registers
// assumes it is included by bare name from the top-level design file
`ifndef TLBT_MAP_SVH
`define TLBT_MAP_SVH
`define TLBT_SEL_CMD 1'b0
`define TLBT_SEL_DATA 1'b1
`define TLBT_CMD_LIN_HI 31
`define TLBT_CMD_LIN_LO 12
`define TLBT_CMD_SET_HI 14
`define TLBT_CMD_TAG_LO 15
`define TLBT_CMD_V_BIT 11
`define TLBT_CMD_D_BIT 10
`define TLBT_CMD_DN_BIT 9
`define TLBT_CMD_U_BIT 8
`define TLBT_CMD_UN_BIT 7
`define TLBT_CMD_W_BIT 6
`define TLBT_CMD_WN_BIT 5
`define TLBT_CMD_OP_BIT 0
`define TLBT_CMD_MASK 32'hFFFFFFE1
`define TLBT_DAT_PHYS_HI 31
`define TLBT_DAT_PHYS_LO 12
`define TLBT_DAT_CI_BIT 11
`define TLBT_DAT_ST_BIT 10
`define TLBT_DAT_LRU_HI 9
`define TLBT_DAT_LRU_LO 7
`define TLBT_DAT_FLAG_BIT 4
`define TLBT_DAT_PTR_HI 3
`define TLBT_DAT_PTR_LO 2
`define TLBT_RST_WORD 32'h00000000
`define TLBT_RST_LRU 3'h0
`endif

// ---- src/tlbt_pkg.sv ----
// types shared by the translation buffer test access logic
// assumes nothing beyond a SystemVerilog compiler
package tlbt_pkg;
    typedef logic [2:0] tlbt_lru_t;
    typedef logic [1:0] tlbt_way_t;
    typedef logic [2:0] tlbt_set_t;
    // tag entry: 17-bit tag and four protection bits, 21 bits
    typedef struct packed {
        logic [16:0] tag;
        logic valid;
        logic user;
        logic rw;
        logic dirty;
    } tlbt_tag_t;
    // data entry: 20-bit page address and two attributes, 22 bits
    typedef struct packed {
        logic [19:0] phys;
        logic page_cache_inhibit;
        logic page_store_through;
    } tlbt_data_t;
endpackage

// ---- src/tlbt_plru.sv ----
// pseudo-LRU step for one set of four ways: victim choice and most-recent update
// assumes a purely combinational use by the parent
`timescale 1ns/10ps
`default_nettype none
module tlbt_plru (
    input wire logic [2:0] lru_in,
    input wire logic [1:0] used_way,
    output logic [2:0] lru_out,
    output logic [1:0] victim
);
    // bit 0 picks the pair, bit 1 or bit 2 the way inside it; victim ignores used_way
    always_comb begin
        victim = lru_in[0] ? {1'b1, lru_in[2]} : {1'b0, lru_in[1]};
        lru_out = lru_in;
        if (used_way[1] == 1'b0) begin
            lru_out[0] = 1'b1;
            lru_out[1] = ~used_way[0];
        end else begin
            lru_out[0] = 1'b0;
            lru_out[2] = ~used_way[0];
        end
    end
endmodule // tlbt_plru
`default_nettype wire

// ---- sim/tb_tlb_test_access_logic.sv ----
// self-checking bench for the translation buffer test access block
// assumes the design files under src/, one 25 MHz clock and a synchronous low reset
`timescale 1ns/10ps
`default_nettype none
module tb_tlb_test_access_logic;
    logic mclk, resetn, tr_wr_en, tr_wr_sel, tr_rd_en, tr_rd_sel, xl_valid, fill_valid;
    logic [31:0] tr_wr_data, tr_rd_data, v;
    logic tr_rd_valid, xl_done, xl_hit, xl_cache_inhibit, xl_store_through, fill_done;
    logic [19:0] xl_lin, xl_phys, fill_lin, fill_phys, lin_r;
    logic fill_cache_inhibit, fill_store_through, fill_user, fill_rw, fill_dirty;
    integer seed, err_count, tests_run, i;
    // reference copy of the buffer: prot is {valid, user, rw, dirty}
    logic [16:0] m_tag [4][8];
    logic [3:0] m_prot [4][8];
    logic [21:0] m_dat [4][8];
    logic [2:0] m_lru [8];

    tlbt_top DUT (.mclk(mclk), .resetn(resetn), .tr_wr_en(tr_wr_en), .tr_wr_sel(tr_wr_sel),
        .tr_wr_data(tr_wr_data), .tr_rd_en(tr_rd_en), .tr_rd_sel(tr_rd_sel),
        .tr_rd_data(tr_rd_data), .tr_rd_valid(tr_rd_valid), .xl_valid(xl_valid),
        .xl_lin(xl_lin), .xl_done(xl_done), .xl_hit(xl_hit), .xl_phys(xl_phys),
        .xl_cache_inhibit(xl_cache_inhibit), .xl_store_through(xl_store_through),
        .fill_valid(fill_valid), .fill_lin(fill_lin), .fill_phys(fill_phys),
        .fill_cache_inhibit(fill_cache_inhibit), .fill_store_through(fill_store_through),
        .fill_user(fill_user), .fill_rw(fill_rw), .fill_dirty(fill_dirty),
        .fill_done(fill_done));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // most-recent marking and victim choice of the shared pseudo-LRU
    function automatic logic [2:0] touch(input logic [2:0] l, input logic [1:0] w);
        touch = l;
        touch[0] = ~w[1];
        if (w[1]) touch[2] = ~w[0]; else touch[1] = ~w[0];
    endfunction
    function automatic logic [1:0] victim(input logic [2:0] l);
        victim = l[0] ? {1'b1, l[2]} : {1'b0, l[1]};
    endfunction
    // one protection pair on a lookup: 00 never, 01 stored 0, 10 stored 1, 11 always
    function automatic logic pair_ok(input logic b, input logic bn, input logic s);
        pair_ok = b ? (bn | s) : (bn & ~s);
    endfunction
    // returns {hit, way}; a hit needs exactly one matching way so duplicates miss
    function automatic logic [2:0] find(input logic [31:0] c, input logic test);
        int n;
        logic [1:0] hw;
        logic m;
        n = 0;
        hw = 2'h0;
        for (int w = 0; w < 4; w++) begin
            m = m_tag[w][c[14:12]] === c[31:15];
            if (test) m = m && m_prot[w][c[14:12]][3] === c[11] && pair_ok(c[10], c[9],
                m_prot[w][c[14:12]][0]) && pair_ok(c[8], c[7], m_prot[w][c[14:12]][2])
                && pair_ok(c[6], c[5], m_prot[w][c[14:12]][1]);
            else m = m && m_prot[w][c[14:12]][3] === 1'b1;
            if (m) begin
                n++;
                hw = 2'(w);
            end
        end
        find = {n == 1, hw};
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input logic sel, input logic [31:0] d);
        @(posedge mclk);
        tr_wr_en <= 1'b1;
        tr_wr_sel <= sel;
        tr_wr_data <= d;
        @(posedge mclk);
        tr_wr_en <= 1'b0;
    endtask
    task rd(input logic sel, output logic [31:0] d);
        @(posedge mclk);
        tr_rd_en <= 1'b1;
        tr_rd_sel <= sel;
        @(posedge mclk);
        tr_rd_en <= 1'b0;
        #1;
        check({31'h0, tr_rd_valid}, 32'h1);
        d = tr_rd_data;
    endtask
    // data word first, then the command; lru bits and spare bits carry junk on purpose
    task test_write(input logic [19:0] lin, input logic [3:0] p, input logic [21:0] dat,
                    input logic given, input logic [1:0] ptr);
        logic [1:0] w;
        wr(1'b1, {dat, 3'($random(seed)), 2'($random(seed)), given, ptr, 2'($random(seed))});
        wr(1'b0, {lin, p[3], p[0], ~p[0], p[2], ~p[2], p[1], ~p[1], 5'h00});
        w = given ? ptr : victim(m_lru[lin[2:0]]);
        m_tag[w][lin[2:0]] = lin[19:3];
        m_prot[w][lin[2:0]] = p;
        m_dat[w][lin[2:0]] = dat;
        m_lru[lin[2:0]] = touch(m_lru[lin[2:0]], w);
    endtask
    task test_lookup(input logic [31:0] c);
        logic [2:0] f;
        f = find(c, 1'b1);
        wr(1'b0, c);
        rd(1'b1, v);
        if (f[2]) begin
            check(v, {m_dat[f[1:0]][c[14:12]], m_lru[c[14:12]], 3'b001, f[1:0], 2'b00});
            m_lru[c[14:12]] = touch(m_lru[c[14:12]], f[1:0]);
        end else begin
            check(v & 32'h00000010, 32'h00000000);
        end
    endtask
    task do_fill(input logic [19:0] lin, input logic [21:0] dat, input logic [2:0] urd,
                 input logic clash);
        logic [1:0] w;
        w = victim(m_lru[lin[2:0]]);
        @(posedge mclk);
        fill_valid <= 1'b1;
        fill_lin <= lin;
        {fill_phys, fill_cache_inhibit, fill_store_through} <= dat;
        {fill_user, fill_rw, fill_dirty} <= urd;
        if (clash) begin
            // a forced-miss lookup in the same cycle owns the update port, the fill waits
            tr_wr_en <= 1'b1;
            tr_wr_sel <= 1'b0;
            tr_wr_data <= {lin, 12'hE61};
            @(posedge mclk);
            tr_wr_en <= 1'b0;
            #1;
            check({31'h0, fill_done}, 32'h0);
        end
        @(posedge mclk);
        fill_valid <= 1'b0;
        #1;
        check({31'h0, fill_done}, 32'h1);
        m_tag[w][lin[2:0]] = lin[19:3];
        m_prot[w][lin[2:0]] = {1'b1, urd};
        m_dat[w][lin[2:0]] = dat;
        m_lru[lin[2:0]] = touch(m_lru[lin[2:0]], w);
    endtask
    task do_xl(input logic [19:0] lin);
        logic [2:0] f;
        f = find({lin, 12'h000}, 1'b0);
        @(posedge mclk);
        xl_valid <= 1'b1;
        xl_lin <= lin;
        @(posedge mclk);
        xl_valid <= 1'b0;
        #1;
        check({30'h0, xl_done, xl_hit}, {30'h0, 1'b1, f[2]});
        if (f[2]) begin
            v = {10'h0, xl_phys, xl_cache_inhibit, xl_store_through};
            check(v, {10'h0, m_dat[f[1:0]][lin[2:0]]});
            m_lru[lin[2:0]] = touch(m_lru[lin[2:0]], f[1:0]);
        end
    endtask

    // watchdog: the sequence needs some 1700 cycles, give it about twelve times that
    initial begin
        #(40 * 20000);
        err_count++;
        tally_and_finish;
    end

    initial begin
        seed = 32'h6ea18703;
        err_count = 0;
        tests_run = 0;
        {resetn, tr_wr_en, tr_wr_sel, tr_rd_en, tr_rd_sel, xl_valid, fill_valid} = 7'h00;
        {tr_wr_data, xl_lin, fill_lin, fill_phys} = 92'h0;
        {fill_cache_inhibit, fill_store_through, fill_user, fill_rw, fill_dirty} = 5'h00;
        for (i = 0; i < 32; i++) begin
            m_prot[i % 4][i / 4] = 4'h0;
            m_tag[i % 4][i / 4] = 17'h00000;
            m_dat[i % 4][i / 4] = 22'h000000;
            m_lru[i / 4] = 3'h0;
        end
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        rd(1'b0, v);
        check(v, 32'h00000000);
        rd(1'b1, v);
        check(v, 32'h00000000);
        // data register layout, unused bits read 0
        wr(1'b1, 32'($random(seed)));
        rd(1'b1, v);
        check(v, tr_wr_data & 32'hFFFFFF9C);
        // a command write starts a lookup that must miss on an empty buffer
        test_lookup(32'($random(seed)) | 32'h00000801);
        rd(1'b0, v);
        check(v, tr_wr_data & 32'hFFFFFFE1);
        $display("test reset and layout done");
        // explicit way pointer, then wildcard lookups of every way
        for (i = 0; i < 4; i++) test_write({17'h0A5A0 + 17'(i), 3'd5}, 4'(i) | 4'h8,
            22'($random(seed)), 1'b1, 2'(i));
        for (i = 3; i >= 0; i--) test_lookup({17'h0A5A0 + 17'(i), 3'd5, 12'hFE1});
        $display("test explicit ways done");
        // every protection pair code and both valid values
        for (i = 0; i < 128; i++) test_lookup({17'h0A5A2, 3'd5, 7'(i), 5'h01});
        $display("test protection pairs done");
        // one address written twice in a set must not hit
        test_write({17'h0A5A1, 3'd5}, 4'hF, 22'h155555, 1'b1, 2'd0);
        test_lookup({17'h0A5A1, 3'd5, 12'hFE1});
        do_xl({17'h0A5A1, 3'd5});
        $display("test duplicate entry done");
        // internal pointer chooses the way and every write becomes most recent
        for (i = 0; i < 6; i++) test_write({17'h01000 + 17'(i), 3'd2}, 4'h8,
            22'($random(seed)), 1'b0, 2'd3);
        for (i = 0; i < 6; i++) test_lookup({17'h01000 + 17'(i), 3'd2, 12'hFE1});
        $display("test replacement pointer done");
        // test operations mixed with live fills and translations
        for (i = 0; i < 250; i++) begin
            lin_r = {15'h3C5A, 5'($random(seed))};
            @(posedge mclk);
            case (2'($random(seed)))
                2'd0: test_write(lin_r, 4'($random(seed)) | 4'h8, 22'($random(seed)),
                    1'($random(seed)), 2'($random(seed)));
                2'd1: test_lookup({lin_r, 1'b1, 6'($random(seed)), 5'h01});
                2'd2: do_fill(lin_r, 22'($random(seed)), 3'($random(seed)), 1'($random(seed)));
                default: do_xl(lin_r);
            endcase
        end
        $display("test random mix done");
        tally_and_finish;
    end
endmodule // tb_tlb_test_access_logic
`default_nettype wire
